//--- subcmp_pkg.sv
// Purpose: constants for the subtract and compare datapath with its condition codes
// Assumes: 16-bit operands, registers reached over APB with 32-bit data
// Notes: Behaviour list below covers both subtract and compare
// Behaviour
// - subtract writes destination minus source back
// - negative and zero follow the result
// - subtract overflow: opposite signs, source sign matches
// - carry clear on carry out, else borrow
// - compare forms source plus inverted destination plus one
// - compare overflow: opposite signs, destination sign matches
// - compare writes no operand, only updates flags and the result register
`default_nettype none
package subcmp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_INSTR = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_SRC = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_DST = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h010;
  // instruction word layout
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int SRC_FIELD_MSB = 11;
  localparam int SRC_FIELD_LSB = 6;
  localparam int DST_FIELD_MSB = 5;
  localparam int DST_FIELD_LSB = 0;
  localparam logic [3:0] OPC_SUB = 4'he;
  localparam logic [3:0] OPC_CMP_WORD = 4'h2;
  localparam logic [3:0] OPC_CMP_BYTE = 4'ha;
  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_IGNORED = 4;
  localparam int FLAGS_W = 5;
  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [FLAGS_W-1:0] RST_FLAGS = 5'h00;
endpackage
`default_nettype wire

//--- sub_flag_core.sv
// Purpose: ripple subtractor a - b with condition codes, word or byte width
// Assumes: purely combinational, operands already chosen by the caller
// Notes: byte mode zeroes the upper half of the difference
`timescale 1ns/100ps
`default_nettype none
module sub_flag_core
  import subcmp_pkg::*;
(
  input wire logic [subcmp_pkg::DATA_W-1:0] a,
  input wire logic [subcmp_pkg::DATA_W-1:0] b,
  input wire logic byteMode,
  output logic [subcmp_pkg::DATA_W-1:0] diff,
  output logic flagN,
  output logic flagZ,
  output logic flagV,
  output logic flagC
);
  import subcmp_pkg::*;

  logic [DATA_W:0] carry;
  logic [DATA_W-1:0] sum;
  logic signA;
  logic signB;
  logic signR;
  logic carryOut;

  // a + ~b + 1, one full adder per bit
  assign carry[0] = 1'b1;
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    assign sum[i] = a[i] ^ ~b[i] ^ carry[i];
    assign carry[i+1] = (a[i] & ~b[i]) | (carry[i] & (a[i] ^ ~b[i]));
  end

  // byte form takes its signs and carry from bit 7
  assign signA = byteMode ? a[7] : a[DATA_W-1];
  assign signB = byteMode ? b[7] : b[DATA_W-1];
  assign signR = byteMode ? sum[7] : sum[DATA_W-1];
  assign carryOut = byteMode ? carry[8] : carry[DATA_W];
  assign diff = byteMode ? {8'h00, sum[7:0]} : sum;

  assign flagN = signR;
  assign flagZ = (diff == RST_WORD);
  // overflow: operands differ in sign and the subtrahend's sign shows up in the result
  assign flagV = (signA != signB) && (signB == signR);
  // carry out clears C, so a set C reads as a borrow
  assign flagC = ~carryOut;
endmodule
`default_nettype wire

//--- subtract_compare_flag_logic.sv
// Purpose: APB-reached subtract and compare unit with N Z V C condition codes
// Assumes: one clock, synchronous reset, APB master keeps its request until pready
// Notes: writing the instruction register executes it against the operand registers
`timescale 1ns/100ps
`default_nettype none
module subtract_compare_flag_logic
  import subcmp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [subcmp_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [3:0] condFlags
);
  import subcmp_pkg::*;

  logic [DATA_W-1:0] instrWord;
  logic [DATA_W-1:0] srcOp;
  logic [DATA_W-1:0] dstOp;
  logic [DATA_W-1:0] difference;
  logic [FLAGS_W-1:0] flags;
  logic setupPhase;
  logic accessDone;
  logic wrInstr;
  logic [3:0] opcode;
  logic execSub;
  logic execCmpWord;
  logic execCmpByte;
  logic execAny;
  logic [DATA_W-1:0] opA;
  logic [DATA_W-1:0] opB;
  logic [DATA_W-1:0] coreDiff;
  logic coreN;
  logic coreZ;
  logic coreV;
  logic coreC;
  logic mapped;
  logic [31:0] next_prdata;

  // no wait state: pready rises in the first access cycle, so every transfer takes two edges
  assign setupPhase = psel && !penable && !pready;
  assign accessDone = psel && penable && pready;
  assign wrInstr = accessDone && pwrite && (paddr == OFF_INSTR);
  assign opcode = pwdata[OPC_MSB:OPC_LSB];
  assign execSub = wrInstr && (opcode == OPC_SUB);
  assign execCmpWord = wrInstr && (opcode == OPC_CMP_WORD);
  assign execCmpByte = wrInstr && (opcode == OPC_CMP_BYTE);
  assign execAny = execSub || execCmpWord || execCmpByte;

  // subtract takes dst - src, compare the reverse order
  assign opA = execSub ? dstOp : srcOp;
  assign opB = execSub ? srcOp : dstOp;

  sub_flag_core u_core (
    .a(opA),
    .b(opB),
    .byteMode(execCmpByte),
    .diff(coreDiff),
    .flagN(coreN),
    .flagZ(coreZ),
    .flagV(coreV),
    .flagC(coreC)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  assign mapped = (paddr == OFF_INSTR) || (paddr == OFF_SRC) || (paddr == OFF_DST) ||
                  (paddr == OFF_RESULT) || (paddr == OFF_FLAGS);

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      OFF_INSTR: next_prdata = {16'h0000, instrWord};
      OFF_SRC: next_prdata = {16'h0000, srcOp};
      OFF_DST: next_prdata = {16'h0000, dstOp};
      OFF_RESULT: next_prdata = {16'h0000, difference};
      OFF_FLAGS: next_prdata = {27'h0000000, flags};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // read data and error are captured in setup, before any write of this transfer lands
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped || (pwrite && (paddr == OFF_RESULT || paddr == OFF_FLAGS));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      instrWord <= RST_WORD;
    end else if (wrInstr) begin
      instrWord <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      srcOp <= RST_WORD;
    end else if (accessDone && pwrite && paddr == OFF_SRC) begin
      srcOp <= pwdata[DATA_W-1:0];
    end
  end

  // only subtract writes back; compare leaves both operands alone
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dstOp <= RST_WORD;
    end else if (execSub) begin
      dstOp <= coreDiff;
    end else if (accessDone && pwrite && paddr == OFF_DST) begin
      dstOp <= pwdata[DATA_W-1:0];
    end
  end

  // the difference register is a view of the last result, not a destination
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      difference <= RST_WORD;
    end else if (execAny) begin
      difference <= coreDiff;
    end
  end

  // other opcodes leave N Z V C untouched and raise the ignored bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags <= RST_FLAGS;
    end else if (execAny) begin
      flags <= {1'b0, coreN, coreZ, coreV, coreC};
    end else if (wrInstr) begin
      flags[FLAG_IGNORED] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      condFlags <= 4'h0;
    end else if (execAny) begin
      condFlags <= {coreN, coreZ, coreV, coreC};
    end
  end

  property p_sub_writeback;
    @(posedge clk_sys) disable iff (sys_rst)
    execSub |=> dstOp == DATA_W'($past(dstOp) - $past(srcOp));
  endproperty
  a_sub_writeback: assert property (p_sub_writeback) else $error("subtract result not written");

  property p_sub_keeps_src;
    @(posedge clk_sys) disable iff (sys_rst)
    execSub |=> $stable(srcOp) && difference == dstOp;
  endproperty
  a_sub_keeps_src: assert property (p_sub_keeps_src) else $error("subtract disturbed source");

  property p_zero_neg;
    @(posedge clk_sys) disable iff (sys_rst)
    (execSub || execCmpWord) |=>
      flags[FLAG_Z] == (difference == RST_WORD) && flags[FLAG_N] == difference[DATA_W-1];
  endproperty
  a_zero_neg: assert property (p_zero_neg) else $error("N or Z wrong");

  property p_sub_overflow;
    @(posedge clk_sys) disable iff (sys_rst)
    execSub |=> flags[FLAG_V] == (($past(dstOp[15]) != $past(srcOp[15])) &&
                                  ($past(srcOp[15]) == difference[15]));
  endproperty
  a_sub_overflow: assert property (p_sub_overflow) else $error("subtract V wrong");

  property p_sub_borrow;
    @(posedge clk_sys) disable iff (sys_rst)
    execSub |=> flags[FLAG_C] == ($past(dstOp) < $past(srcOp)) && condFlags == flags[3:0];
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("subtract C wrong");

  property p_cmp_order;
    @(posedge clk_sys) disable iff (sys_rst)
    execCmpWord |=> difference == DATA_W'($past(srcOp) - $past(dstOp)) &&
                    flags[FLAG_C] == ($past(srcOp) < $past(dstOp));
  endproperty
  a_cmp_order: assert property (p_cmp_order) else $error("compare order wrong");

  property p_cmp_overflow;
    @(posedge clk_sys) disable iff (sys_rst)
    execCmpWord |=> flags[FLAG_V] == (($past(srcOp[15]) != $past(dstOp[15])) &&
                                      ($past(dstOp[15]) == difference[15]));
  endproperty
  a_cmp_overflow: assert property (p_cmp_overflow) else $error("compare V wrong");

  property p_cmp_no_write;
    @(posedge clk_sys) disable iff (sys_rst)
    (execCmpWord || execCmpByte) |=> $stable(srcOp) && $stable(dstOp);
  endproperty
  a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare modified an operand");

  property p_cmp_byte;
    @(posedge clk_sys) disable iff (sys_rst)
    execCmpByte |=> difference[15:8] == 8'h00 && flags[FLAG_N] == difference[7] &&
                    flags[FLAG_C] == ($past(srcOp[7:0]) < $past(dstOp[7:0]));
  endproperty
  a_cmp_byte: assert property (p_cmp_byte) else $error("byte compare flags wrong");

  // zero and overflow of the byte form look only at the low byte
  property p_cmp_byte_vz;
    @(posedge clk_sys) disable iff (sys_rst)
    execCmpByte |=> flags[FLAG_Z] == (difference[7:0] == 8'h00) &&
                    flags[FLAG_V] == (($past(srcOp[7]) != $past(dstOp[7])) &&
                                      ($past(dstOp[7]) == difference[7]));
  endproperty
  a_cmp_byte_vz: assert property (p_cmp_byte_vz) else $error("byte compare Z or V wrong");

  // the bus answer is a single-cycle pulse right after setup
  property p_ready_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
    setupPhase |=> pready ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready not a one-cycle answer");
endmodule
`default_nettype wire

//--- apb_master_model.sv
// Purpose: APB requester standing in for the decoder and operand fetch side
// Assumes: go pulses only while idle
// Notes: write data inverts after release so stale data never passes as valid
`timescale 1ns/100ps
`default_nettype none
module apb_master_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic wr,
  input wire logic [subcmp_pkg::ADDR_W-1:0] adr,
  input wire logic [31:0] wdat,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [subcmp_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic done,
  output logic [31:0] rdat,
  output logic err
);
  import subcmp_pkg::*;
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    if (sys_rst) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= '0;
      pwdata <= '0;
      rdat <= '0;
      err <= 1'b0;
    end else if (psel && penable && pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~pwdata;
      rdat <= prdata;
      err <= pslverr;
      done <= 1'b1;
    end else if (psel) begin
      penable <= 1'b1;
    end else if (go) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wdat;
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: random and corner checks of subtract and compare codes over APB
// Assumes: zero-wait-state APB slave
// Notes: expectations come from a bench model of the arithmetic
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import subcmp_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst, go, wr, psel, penable, pwrite, pready, pslverr, done, err;
  logic [ADDR_W-1:0] adr, paddr;
  logic [31:0] wdat, pwdata, prdata, rdat;
  logic [3:0] condFlags;
  int failures = 0;
  int check_count = 0;
  always #2 clk_sys = ~clk_sys;
  apb_master_model mst_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .wr(wr),
    .adr(adr), .wdat(wdat), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .done(done), .rdat(rdat), .err(err));
  subtract_compare_flag_logic dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .condFlags(condFlags));
  task automatic summarize();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wr <= w;
    adr <= a;
    wdat <= d;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 20) failures++;
    chk(n, 2);
  endtask
  // {result, N, Z, V, C}; minuend a, subtrahend b
  function automatic logic [19:0] model(input logic [3:0] op, input logic [15:0] s,
      input logic [15:0] d);
    logic [16:0] r;
    logic [15:0] a, b;
    logic v;
    a = (op == OPC_SUB) ? d : s;
    b = (op == OPC_SUB) ? s : d;
    if (op == OPC_CMP_BYTE) begin
      r = {9'h0, a[7:0]} - {9'h0, b[7:0]};
      v = (a[7] != b[7]) && (b[7] == r[7]);
      return {8'h0, r[7:0], r[7], r[7:0] == 8'h0, v, r[8]};
    end
    r = {1'b0, a} - {1'b0, b};
    v = (a[15] != b[15]) && (b[15] == r[15]);
    return {r[15:0], r[15], r[15:0] == 16'h0, v, r[16]};
  endfunction
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    summarize();
  end
  initial begin
    logic [15:0] s, d;
    logic [19:0] e;
    logic [3:0] op;
    int seed;
    seed = 71;
    sys_rst = 1'b1;
    go = 1'b0;
    wr = 1'b0;
    adr = '0;
    wdat = '0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    xfer(0, OFF_FLAGS, 0);
    chk(rdat, 32'h0);
    chk({28'h0, condFlags}, 32'h0);
    for (int i = 0; i < 48; i++) begin
      op = (i % 3 == 0) ? OPC_SUB : (i % 3 == 1) ? OPC_CMP_WORD : OPC_CMP_BYTE;
      s = 16'($random(seed));
      d = 16'($random(seed));
      if (i < 3) s = 16'h8000;
      if (i < 3) d = 16'h1201;
      if (i >= 3 && i < 6) d = s;
      e = model(op, s, d);
      xfer(1, OFF_SRC, {16'h0, s});
      xfer(1, OFF_DST, {16'h0, d});
      xfer(1, OFF_INSTR, {16'h0, op, s[11:0]});
      chk({28'h0, condFlags}, {28'h0, e[3:0]}); // codes
      xfer(0, OFF_RESULT, 0);
      chk(rdat, {16'h0, e[19:4]}); // difference
      xfer(0, OFF_DST, 0);
      chk(rdat, {16'h0, (op == OPC_SUB) ? e[19:4] : d}); // writeback
      xfer(0, OFF_SRC, 0);
      chk(rdat, {16'h0, s}); // source kept
      xfer(0, OFF_FLAGS, 0);
      chk(rdat, {28'h0, e[3:0]}); // status
    end
    xfer(0, 12'h014, 0);
    chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    xfer(1, OFF_RESULT, 32'h5);
    chk({31'h0, err}, 32'h1);
    xfer(1, OFF_INSTR, 32'h1000);
    xfer(0, OFF_FLAGS, 0);
    chk(rdat, {28'h1, e[3:0]});
    chk({28'h0, condFlags}, {28'h0, e[3:0]});
    xfer(0, OFF_INSTR, 0);
    chk(rdat, 32'h1000);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    xfer(0, OFF_DST, 0);
    chk(rdat, 32'h0);
    chk({28'h0, condFlags}, 32'h0);
    xfer(0, OFF_FLAGS, 0);
    chk(rdat, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
